// >>> hdl/bias_ctrl_pkg.sv
/*
 * Constants, register map and carrier types of the backlight and display bias
 * control register bank.
 * Assumes a 10 MHz system clock and a serial bus front end that hands over
 * decoded byte events (address byte, data byte written, read byte acknowledged).
 */
`default_nettype none

package bias_ctrl_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_MHZ = 10;
	localparam int FILT_2MS_US = 2000;
	localparam int FILT_1MS_US = 1000;
	localparam int FILT_500US_US = 500;
	localparam int FILT_100US_US = 100;
	localparam int FILT_100US_CYC = FILT_100US_US * CLK_MHZ;
	localparam int FILT_W = 16;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_CFG_B = 8'h03;
	localparam logic [7:0] ADDR_BRT_LOW = 8'h04;
	localparam logic [7:0] ADDR_BRT_HIGH = 8'h05;
	localparam logic [7:0] ADDR_AF_LOW = 8'h06;
	localparam logic [7:0] ADDR_AF_HIGH = 8'h07;
	localparam logic [7:0] ADDR_ENABLE = 8'h08;
	localparam logic [7:0] ADDR_BIAS_A = 8'h09;
	localparam logic [7:0] ADDR_BIAS_B = 8'h0A;
	localparam logic [7:0] ADDR_BIAS_C = 8'h0B;
	localparam logic [7:0] ADDR_BOOST_LVL = 8'h0C;
	localparam logic [7:0] ADDR_POS_LVL = 8'h0D;
	localparam logic [7:0] ADDR_NEG_LVL = 8'h0E;
	localparam logic [7:0] ADDR_FLAGS = 8'h0F;
	localparam logic [7:0] ADDR_OPT_A = 8'h10;
	localparam int REG_COUNT = 14;

	// Reset values
	localparam logic [7:0] RST_CFG_B = 8'h8D;
	localparam logic [7:0] RST_BRT_LOW = 8'h07;
	localparam logic [7:0] RST_BRT_HIGH = 8'hFF;
	localparam logic [7:0] RST_AF = 8'h00;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_BIAS_A = 8'h18;
	localparam logic [7:0] RST_BIAS_B = 8'h11;
	localparam logic [7:0] RST_BIAS_C = 8'h00;
	localparam logic [7:0] RST_BOOST_LVL = 8'h28;
	localparam logic [7:0] RST_POS_LVL = 8'h1E;
	localparam logic [7:0] RST_NEG_LVL = 8'h1C;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_OPT_A = 8'h06;

	// Writable bit masks and the implemented flag bit mask
	localparam logic [7:0] MASK_ALL = 8'hFF;
	localparam logic [7:0] MASK_BRT_LOW = 8'h07;
	localparam logic [7:0] MASK_ENABLE = 8'h1F;
	localparam logic [7:0] MASK_BIAS_C = 8'h33;
	localparam logic [7:0] MASK_LVL = 8'h3F;
	localparam logic [7:0] MASK_FLAGS = 8'h6F;
	localparam logic [7:0] MASK_OPT_A = 8'h7F;
	localparam logic [7:0] MASK_NONE = 8'h00;

	// Field positions
	localparam int CFGB_FREQ = 7;
	localparam int CFGB_RAMP_LSB = 3;
	localparam int CFGB_SAMPLE = 2;
	localparam int CFGB_HYST_LSB = 0;
	localparam int EN_RESET = 7;
	localparam int EN_BACKLIGHT = 4;
	localparam int EN_SINK_TWO = 1;
	localparam int EN_SINK_ONE = 0;
	localparam int BA_MODE_LSB = 5;
	localparam int BA_POS_PD = 4;
	localparam int BA_NEG_PD = 3;
	localparam int BA_POS_ON = 2;
	localparam int BA_NEG_ON = 1;
	localparam int BA_PIN_SEL = 0;
	localparam int BB_SHORT_LSB = 6;
	localparam int BB_RISE_LSB = 4;
	localparam int BB_FALL_LSB = 0;
	localparam int BC_POS_FILT_LSB = 4;
	localparam int BC_NEG_FILT_LSB = 0;
	localparam int OPT_FAST_SAMPLE = 0;
	localparam int FL_OVERTEMP = 6;
	localparam int FL_BOOST_OV = 5;
	localparam int FL_POS_SHORT = 3;
	localparam int FL_NEG_SHORT = 2;
	localparam int FL_BL_OV = 1;
	localparam int FL_BL_OC = 0;

	// Encodings
	localparam logic [2:0] BIAS_MODE_OFF = 3'h0;
	localparam logic [5:0] LEVEL_MAX_CODE = 6'h32;
	localparam logic [1:0] SAMPLE_1MHZ = 2'h0;
	localparam logic [1:0] SAMPLE_4MHZ = 2'h1;
	localparam logic [1:0] SAMPLE_24MHZ = 2'h2;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic overtemperature_flag;
		logic bias_boost_overvoltage_flag;
		logic positive_short_flag;
		logic negative_short_flag;
		logic backlight_overvoltage_flag;
		logic backlight_overcurrent_flag;
	} fault_s;

	typedef struct packed {
		logic boost_switch_freq_sel;
		logic [3:0] brightness_transition_time;
		logic [1:0] sample_rate_sel;
		logic [2:0] dimming_input_hysteresis;
		logic [10:0] brightness_code;
		logic auto_freq_above_high;
		logic auto_freq_below_low;
		logic backlight_on;
		logic sink_one_on;
		logic sink_two_on;
		logic [2:0] bias_mode_select;
		logic positive_out_on;
		logic negative_out_on;
		logic positive_out_pulldown;
		logic negative_out_pulldown;
		logic [1:0] positive_rise_time;
		logic [3:0] negative_fall_time;
		logic [5:0] bias_boost_level;
		logic [5:0] positive_bias_level;
		logic [5:0] negative_bias_level;
	} ctrl_s;

endpackage : bias_ctrl_pkg

`default_nettype wire

// >>> hdl/bias_ctrl_regs.sv
/*
 * Register bank of the backlight and bias controller with fault flags, short
 * filters and derived control outputs.
 * Assumes the serial bus front end delivers one-cycle byte events synchronous
 * to i_sys_clk and that analog comparators drive the fault inputs.
 */
`default_nettype none

module bias_ctrl_regs #(
	parameter int P_FILT_2MS_CYC = bias_ctrl_pkg::FILT_2MS_US * bias_ctrl_pkg::CLK_MHZ,
	parameter int P_FILT_1MS_CYC = bias_ctrl_pkg::FILT_1MS_US * bias_ctrl_pkg::CLK_MHZ,
	parameter int P_FILT_500US_CYC = bias_ctrl_pkg::FILT_500US_US * bias_ctrl_pkg::CLK_MHZ
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_addr_load,
	input wire logic i_data_wr,
	input wire logic i_rd_ack,
	input wire logic [7:0] i_byte,
	input wire logic i_positive_enable_pin,
	input wire logic i_negative_enable_pin,
	input wire bias_ctrl_pkg::fault_s i_fault,
	output logic [7:0] o_rdata,
	output bias_ctrl_pkg::ctrl_s o_ctrl
);
	import bias_ctrl_pkg::*;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic in_map(input logic [7:0] a);
		in_map = (a >= ADDR_CFG_B) && (a <= ADDR_OPT_A);
	endfunction : in_map

	function automatic logic [3:0] to_index(input logic [7:0] a);
		logic [7:0] d;
		d = a - ADDR_CFG_B;
		to_index = d[3:0];
	endfunction : to_index

	function automatic logic [7:0] reg_mask(input logic [7:0] a);
		reg_mask = MASK_NONE;
		unique case (a)
			ADDR_BRT_LOW: reg_mask = MASK_BRT_LOW;
			ADDR_ENABLE: reg_mask = MASK_ENABLE;
			ADDR_BIAS_C: reg_mask = MASK_BIAS_C;
			ADDR_BOOST_LVL, ADDR_POS_LVL, ADDR_NEG_LVL: reg_mask = MASK_LVL;
			ADDR_FLAGS: reg_mask = MASK_NONE;
			ADDR_OPT_A: reg_mask = MASK_OPT_A;
			ADDR_CFG_B, ADDR_BRT_HIGH, ADDR_AF_LOW, ADDR_AF_HIGH, ADDR_BIAS_A,
			ADDR_BIAS_B: reg_mask = MASK_ALL;
			default: reg_mask = MASK_NONE;
		endcase
	endfunction : reg_mask

	function automatic logic [7:0] reg_reset(input logic [7:0] a);
		reg_reset = RST_AF;
		unique case (a)
			ADDR_CFG_B: reg_reset = RST_CFG_B;
			ADDR_BRT_LOW: reg_reset = RST_BRT_LOW;
			ADDR_BRT_HIGH: reg_reset = RST_BRT_HIGH;
			ADDR_ENABLE: reg_reset = RST_ENABLE;
			ADDR_BIAS_A: reg_reset = RST_BIAS_A;
			ADDR_BIAS_B: reg_reset = RST_BIAS_B;
			ADDR_BIAS_C: reg_reset = RST_BIAS_C;
			ADDR_BOOST_LVL: reg_reset = RST_BOOST_LVL;
			ADDR_POS_LVL: reg_reset = RST_POS_LVL;
			ADDR_NEG_LVL: reg_reset = RST_NEG_LVL;
			ADDR_FLAGS: reg_reset = RST_FLAGS;
			ADDR_OPT_A: reg_reset = RST_OPT_A;
			default: reg_reset = RST_AF;
		endcase
	endfunction : reg_reset

	function automatic logic [2:0] hyst_bits(input logic [1:0] code, input logic fast);
		if (fast) begin
			hyst_bits = {1'b0, code};
		end else begin
			unique case (code)
				2'h0: hyst_bits = 3'h1;
				2'h1: hyst_bits = 3'h2;
				2'h2: hyst_bits = 3'h4;
				2'h3: hyst_bits = 3'h6;
			endcase
		end
	endfunction : hyst_bits

	function automatic logic [5:0] sat_level(input logic [5:0] code);
		sat_level = (code > LEVEL_MAX_CODE) ? LEVEL_MAX_CODE : code;
	endfunction : sat_level

	function automatic logic [FILT_W-1:0] filt_limit(input logic [1:0] code);
		unique case (code)
			2'h0: filt_limit = FILT_W'(P_FILT_2MS_CYC);
			2'h1: filt_limit = FILT_W'(P_FILT_1MS_CYC);
			2'h2: filt_limit = FILT_W'(P_FILT_500US_CYC);
			2'h3: filt_limit = FILT_W'(FILT_100US_CYC);
		endcase
	endfunction : filt_limit

	// ****************************************************************
	// Register storage and pointer
	// ****************************************************************
	logic [7:0] regs [REG_COUNT];
	logic [7:0] next_regs [REG_COUNT];
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic [7:0] next_rdata;
	logic [FILT_W-1:0] pos_cnt;
	logic [FILT_W-1:0] neg_cnt;
	logic [FILT_W-1:0] next_pos_cnt;
	logic [FILT_W-1:0] next_neg_cnt;
	ctrl_s next_ctrl;
	logic [7:0] flags;
	logic [7:0] next_flags;
	logic [7:0] flag_set;
	logic pos_short_hit;
	logic neg_short_hit;
	logic soft_reset;

	assign flags = regs[to_index(ADDR_FLAGS)];

	// Short filters: a raw short must persist for the chosen time to count
	always_comb begin
		logic [7:0] bc;
		bc = regs[to_index(ADDR_BIAS_C)];
		next_pos_cnt = '0;
		next_neg_cnt = '0;
		if (i_fault.positive_short_flag && o_ctrl.positive_out_on) begin
			next_pos_cnt = (pos_cnt == filt_limit(bc[BC_POS_FILT_LSB +: 2])) ? pos_cnt
				: pos_cnt + 1'b1;
		end
		if (i_fault.negative_short_flag && o_ctrl.negative_out_on) begin
			next_neg_cnt = (neg_cnt == filt_limit(bc[BC_NEG_FILT_LSB +: 2])) ? neg_cnt
				: neg_cnt + 1'b1;
		end
	end

	assign pos_short_hit = (pos_cnt == filt_limit(regs[to_index(ADDR_BIAS_C)][BC_POS_FILT_LSB +: 2]));
	assign neg_short_hit = (neg_cnt == filt_limit(regs[to_index(ADDR_BIAS_C)][BC_NEG_FILT_LSB +: 2]));
	assign soft_reset = i_data_wr && (ptr == ADDR_ENABLE) && i_byte[EN_RESET];

	// Register file, pointer and flags
	always_comb begin
		flag_set = '0;
		flag_set[FL_OVERTEMP] = i_fault.overtemperature_flag;
		flag_set[FL_BOOST_OV] = i_fault.bias_boost_overvoltage_flag;
		flag_set[FL_POS_SHORT] = pos_short_hit;
		flag_set[FL_NEG_SHORT] = neg_short_hit;
		flag_set[FL_BL_OV] = i_fault.backlight_overvoltage_flag;
		flag_set[FL_BL_OC] = i_fault.backlight_overcurrent_flag;
		next_regs = regs;
		next_ptr = ptr;
		next_flags = flags;
		if (i_addr_load) begin
			next_ptr = i_byte;
		end else if (i_data_wr || i_rd_ack) begin
			next_ptr = ptr + 8'h01;
		end
		// Flags clear when read and acknowledged; a fault in that cycle still sets
		if (i_rd_ack && ptr == ADDR_FLAGS) begin
			next_flags = '0;
		end
		next_flags = (next_flags | flag_set) & MASK_FLAGS;
		if (soft_reset) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				next_regs[i] = reg_reset(ADDR_CFG_B + 8'(i));
			end
			// A fault arriving with the reset write still latches its flag
			next_regs[to_index(ADDR_FLAGS)] = flag_set & MASK_FLAGS;
		end else begin
			if (i_data_wr && in_map(ptr)) begin
				next_regs[to_index(ptr)] = i_byte & reg_mask(ptr);
			end
			next_regs[to_index(ADDR_FLAGS)] = next_flags;
		end
		next_rdata = in_map(next_ptr) ? next_regs[to_index(next_ptr)] : 8'h00;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= reg_reset(ADDR_CFG_B + 8'(i));
			end
			ptr <= 8'h00;
			o_rdata <= 8'h00;
			pos_cnt <= '0;
			neg_cnt <= '0;
		end else begin
			regs <= next_regs;
			ptr <= next_ptr;
			o_rdata <= next_rdata;
			pos_cnt <= next_pos_cnt;
			neg_cnt <= next_neg_cnt;
		end
	end

	// ****************************************************************
	// Derived controls
	// ****************************************************************
	// Outputs follow the registers with one cycle of delay so each is a flop
	always_comb begin
		logic [7:0] cb;
		logic [7:0] en;
		logic [7:0] ba;
		logic [7:0] bb;
		logic fast;
		logic bias_kill;
		logic bl_kill;
		logic pos_req;
		logic neg_req;
		cb = regs[to_index(ADDR_CFG_B)];
		en = regs[to_index(ADDR_ENABLE)];
		ba = regs[to_index(ADDR_BIAS_A)];
		bb = regs[to_index(ADDR_BIAS_B)];
		fast = regs[to_index(ADDR_OPT_A)][OPT_FAST_SAMPLE];
		// Shutdown holds until the latched short flag is read away
		bias_kill = bb[BB_SHORT_LSB + 1] && (flags[FL_POS_SHORT] || flags[FL_NEG_SHORT]);
		bl_kill = bias_kill && bb[BB_SHORT_LSB];
		pos_req = ba[BA_PIN_SEL] ? i_positive_enable_pin : ba[BA_POS_ON];
		neg_req = ba[BA_PIN_SEL] ? i_negative_enable_pin : ba[BA_NEG_ON];
		next_ctrl.boost_switch_freq_sel = cb[CFGB_FREQ];
		next_ctrl.brightness_transition_time = cb[CFGB_RAMP_LSB +: 4];
		next_ctrl.sample_rate_sel = fast ? SAMPLE_24MHZ
			: (cb[CFGB_SAMPLE] ? SAMPLE_4MHZ : SAMPLE_1MHZ);
		next_ctrl.dimming_input_hysteresis = hyst_bits(cb[CFGB_HYST_LSB +: 2], fast);
		next_ctrl.brightness_code = {regs[to_index(ADDR_BRT_HIGH)],
			regs[to_index(ADDR_BRT_LOW)][2:0]};
		next_ctrl.auto_freq_above_high =
			regs[to_index(ADDR_BRT_HIGH)] >= regs[to_index(ADDR_AF_HIGH)];
		next_ctrl.auto_freq_below_low =
			regs[to_index(ADDR_BRT_HIGH)] < regs[to_index(ADDR_AF_LOW)];
		next_ctrl.backlight_on = en[EN_BACKLIGHT] && !bl_kill;
		next_ctrl.sink_one_on = en[EN_SINK_ONE];
		next_ctrl.sink_two_on = en[EN_SINK_TWO];
		next_ctrl.bias_mode_select = ba[BA_MODE_LSB +: 3];
		next_ctrl.positive_out_on = pos_req && !bias_kill
			&& ba[BA_MODE_LSB +: 3] != BIAS_MODE_OFF;
		next_ctrl.negative_out_on = neg_req && !bias_kill
			&& ba[BA_MODE_LSB +: 3] != BIAS_MODE_OFF;
		next_ctrl.positive_out_pulldown = ba[BA_POS_PD] && !next_ctrl.positive_out_on;
		next_ctrl.negative_out_pulldown = ba[BA_NEG_PD] && !next_ctrl.negative_out_on;
		next_ctrl.positive_rise_time = bb[BB_RISE_LSB +: 2];
		next_ctrl.negative_fall_time = bb[BB_FALL_LSB +: 4];
		next_ctrl.bias_boost_level = regs[to_index(ADDR_BOOST_LVL)][5:0];
		next_ctrl.positive_bias_level = sat_level(regs[to_index(ADDR_POS_LVL)][5:0]);
		next_ctrl.negative_bias_level = sat_level(regs[to_index(ADDR_NEG_LVL)][5:0]);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_ctrl <= '0;
		end else begin
			o_ctrl <= next_ctrl;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb_chk @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_ptr_advance: assert property ((i_data_wr && !i_addr_load) |=> ptr == $past(ptr) + 8'h01)
		else $error("pointer did not advance after data byte");
	a_soft_reset: assert property (soft_reset |=> regs[to_index(ADDR_CFG_B)] == RST_CFG_B
		&& regs[to_index(ADDR_ENABLE)] == RST_ENABLE)
		else $error("self_clearing_device_reset did not restore registers");
	a_reset_bit_zero: assert property (o_rdata[EN_RESET] == 1'b0 || ptr != ADDR_ENABLE)
		else $error("reset bit read back as one");
	a_unused_zero: assert property (i_data_wr && ptr == ADDR_BRT_LOW && !soft_reset
		|=> regs[to_index(ADDR_BRT_LOW)][7:3] == 5'h00)
		else $error("unused bits stored");
	a_bright_code: assert property ($past(i_rst_n) |-> o_ctrl.brightness_code[10:3]
		== $past(regs[to_index(ADDR_BRT_HIGH)]))
		else $error("brightness code mismatch");
	a_pin_select: assert property (regs[to_index(ADDR_BIAS_A)][BA_PIN_SEL]
		&& !i_positive_enable_pin |=> !o_ctrl.positive_out_on)
		else $error("positive output on without pin");
	a_level_sat: assert property (o_ctrl.positive_bias_level <= LEVEL_MAX_CODE
		&& o_ctrl.negative_bias_level <= LEVEL_MAX_CODE)
		else $error("bias level above limit");
	a_short_kill: assert property (regs[to_index(ADDR_BIAS_B)][7:6] == 2'h3
		&& flags[FL_POS_SHORT] |=> !o_ctrl.backlight_on && !o_ctrl.negative_out_on)
		else $error("short did not shut down outputs");
	a_flag_sticky: assert property (i_fault.overtemperature_flag |=> flags[FL_OVERTEMP])
		else $error("overtemperature flag not set");
	a_pulldown_off: assert property (o_ctrl.positive_out_on |-> !o_ctrl.positive_out_pulldown)
		else $error("pulldown while output on");
	a_fast_sample: assert property (regs[to_index(ADDR_OPT_A)][OPT_FAST_SAMPLE]
		|=> o_ctrl.sample_rate_sel == SAMPLE_24MHZ)
		else $error("fast sample not applied");

	c_burst_write: cover property (i_data_wr ##1 i_data_wr ##1 i_data_wr);
	c_soft_reset: cover property (soft_reset);
	c_short_kill: cover property (flags[FL_POS_SHORT] && !o_ctrl.positive_out_on);
	c_flag_read: cover property (i_rd_ack && ptr == ADDR_FLAGS && flags != 8'h00);

endmodule : bias_ctrl_regs

`default_nettype wire

// >>> dv/bias_host_model.sv
/*
 * Host model of the register port: issues address loads, data writes and
 * read acknowledges as one-cycle byte events, and keeps its own copy of the pointer.
 * Assumes the bench calls its tasks and that i_sys_clk also clocks the block.
 */
`default_nettype none

module bias_host (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_rdata,
	output var logic o_addr_load,
	output var logic o_data_wr,
	output var logic o_rd_ack,
	output var logic [7:0] o_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	import bias_ctrl_pkg::*;

	logic [7:0] ptr;

	// ****************************************************************
	// Idle state
	// ****************************************************************
	initial begin
		o_addr_load = 1'h0;
		o_data_wr = 1'h0;
		o_rd_ack = 1'h0;
		o_byte = 8'h00;
		ptr = 8'h00;
	end

	// ****************************************************************
	// Byte events
	// ****************************************************************
	// A released byte lane shows the inverse, so a stale value never looks valid
	task automatic set_addr(input logic [7:0] a);
		@(posedge i_sys_clk);
		o_addr_load <= 1'h1;
		o_byte <= a;
		@(posedge i_sys_clk);
		o_addr_load <= 1'h0;
		o_byte <= ~a;
		ptr = a;
	endtask : set_addr

	task automatic put(input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (ptr == ADDR_ENABLE) begin
			v[3:2] = 2'h0;
		end
		@(posedge i_sys_clk);
		o_data_wr <= 1'h1;
		o_byte <= v;
		@(posedge i_sys_clk);
		o_data_wr <= 1'h0;
		o_byte <= ~v;
		ptr = ptr + 8'h01;
	endtask : put

	task automatic get(output logic [7:0] d);
		@(posedge i_sys_clk);
		o_rd_ack <= 1'h1;
		@(posedge i_sys_clk);
		d = i_rdata;
		o_rd_ack <= 1'h0;
		ptr = ptr + 8'h01;
	endtask : get

endmodule : bias_host

`default_nettype wire

// >>> dv/testbench.sv
/*
 * Self-checking bench of the backlight and bias register bank.
 * Assumes bias_ctrl_regs and the host model; 2 ms, 1 ms and 500 us filters shortened by parameter, 100 us kept.
 */
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import bias_ctrl_pkg::*;

	logic sys_clk, rst_n, addr_load, data_wr, rd_ack, pos_pin, neg_pin;
	logic [7:0] lane, dout, rdata;
	fault_s fault;
	ctrl_s ctrl;
	int errors, checks;
	localparam logic [7:0] RST_TAB [15] = '{RST_CFG_B, RST_BRT_LOW, RST_BRT_HIGH, RST_AF,
		RST_AF, RST_ENABLE, RST_BIAS_A, RST_BIAS_B, RST_BIAS_C, RST_BOOST_LVL, RST_POS_LVL,
		RST_NEG_LVL, RST_FLAGS, RST_OPT_A, 8'h00};
	localparam logic [7:0] RD_TAB [15] = '{8'hFF, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h13, 8'hFF,
		8'hFF, 8'h33, 8'h3F, 8'h3F, 8'h3F, 8'h00, 8'h7F, 8'h00};
	localparam logic [2:0] HYS_SLOW [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
	localparam logic [2:0] HYS_FAST [4] = '{3'h0, 3'h1, 3'h2, 3'h3};
	localparam logic [2:0] MODES [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
	localparam logic [7:0] SHORT_MODES [3] = '{8'h00, 8'h80, 8'hC0};
	localparam logic [1:0] SHORT_KEEP [3] = '{2'h3, 2'h2, 2'h0};

	// ****************************************************************
	// Block and host
	// ****************************************************************
	bias_ctrl_regs #(.P_FILT_2MS_CYC(40), .P_FILT_1MS_CYC(20), .P_FILT_500US_CYC(10)) u_dut (
		.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_addr_load(addr_load), .i_data_wr(data_wr),
		.i_rd_ack(rd_ack), .i_byte(lane), .i_positive_enable_pin(pos_pin),
		.i_negative_enable_pin(neg_pin), .i_fault(fault), .o_rdata(dout), .o_ctrl(ctrl));
	bias_host u_host (.i_sys_clk(sys_clk), .i_rdata(dout), .o_addr_load(addr_load),
		.o_data_wr(data_wr), .o_rd_ack(rd_ack), .o_byte(lane));

	always #50 sys_clk = ~sys_clk;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Control bundle lags a strobe by two cycles
	task automatic settle;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : settle

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.set_addr(a);
		u_host.put(d);
		settle();
	endtask : wr

	task automatic rd(input logic [7:0] a);
		u_host.set_addr(a);
		u_host.get(rdata);
	endtask : rd

	task automatic pulse(input fault_s f, input int n);
		@(posedge sys_clk);
		fault <= f;
		repeat (n) @(posedge sys_clk);
		fault <= '0;
	endtask : pulse

	task automatic test_done;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset_values;
		u_host.set_addr(ADDR_CFG_B);
		for (int i = 0; i < 15; i++) begin
			u_host.get(rdata);
			chk(rdata, RST_TAB[i], "reset value");
		end
		settle();
		chk(ctrl.boost_switch_freq_sel, 16'h1, "freq");
		chk(ctrl.brightness_transition_time, 16'h1, "ramp");
		chk(ctrl.sample_rate_sel, SAMPLE_4MHZ, "sample");
		chk(ctrl.dimming_input_hysteresis, 16'h2, "hyst");
		chk(ctrl.brightness_code, 16'h7FF, "code");
		chk({ctrl.backlight_on, ctrl.sink_one_on, ctrl.sink_two_on}, 16'h0, "enables");
		chk({ctrl.positive_out_pulldown, ctrl.negative_out_pulldown}, 16'h3, "pulldown");
		chk(ctrl.positive_rise_time, 16'h1, "rise");
		chk(ctrl.negative_fall_time, 16'h1, "fall");
		chk(ctrl.bias_boost_level, 16'h28, "boost");
		chk(ctrl.positive_bias_level, 16'h1E, "pos");
		chk(ctrl.negative_bias_level, 16'h1C, "neg");
		$display("test reset values done");
	endtask : t_reset_values

	// Dimming settings are written and checked here while the backlight is still off
	task automatic t_dimming;
		for (int f = 0; f < 2; f++) begin
			wr(ADDR_OPT_A, 8'(f));
			for (int h = 0; h < 4; h++) begin
				wr(ADDR_CFG_B, 8'h04 | 8'(h));
				chk(ctrl.dimming_input_hysteresis, f ? HYS_FAST[h] : HYS_SLOW[h], "hyst");
				chk(ctrl.sample_rate_sel, f ? SAMPLE_24MHZ : SAMPLE_4MHZ, "sample");
			end
		end
		wr(ADDR_OPT_A, 8'h00);
		wr(ADDR_CFG_B, 8'h00);
		chk(ctrl.sample_rate_sel, SAMPLE_1MHZ, "sample");
		chk({ctrl.boost_switch_freq_sel, ctrl.brightness_transition_time}, 16'h0, "cfg");
		wr(ADDR_BRT_LOW, 8'h05);
		wr(ADDR_BRT_HIGH, 8'hA3);
		chk(ctrl.brightness_code, 16'h51D, "code");
		wr(ADDR_AF_LOW, 8'hA4);
		wr(ADDR_AF_HIGH, 8'hA3);
		chk({ctrl.auto_freq_above_high, ctrl.auto_freq_below_low}, 16'h3, "af");
		wr(ADDR_AF_LOW, 8'hA3);
		wr(ADDR_AF_HIGH, 8'hA4);
		chk({ctrl.auto_freq_above_high, ctrl.auto_freq_below_low}, 16'h0, "af");
		$display("test dimming done");
	endtask : t_dimming

	task automatic t_masks;
		u_host.set_addr(ADDR_CFG_B);
		for (int i = 0; i < 15; i++) begin
			u_host.put((i == 5) ? 8'h1F : 8'hFF);
		end
		u_host.set_addr(ADDR_CFG_B);
		for (int i = 0; i < 15; i++) begin
			u_host.get(rdata);
			chk(rdata, RD_TAB[i], "readback");
		end
		settle();
		chk({ctrl.backlight_on, ctrl.sink_one_on, ctrl.sink_two_on}, 16'h7, "enables");
		chk({ctrl.positive_rise_time, ctrl.negative_fall_time}, 16'h3F, "ramps");
		chk(ctrl.bias_boost_level, 16'h3F, "boost");
		chk({ctrl.positive_bias_level, ctrl.negative_bias_level}, 16'hCB2, "sat");
		chk(ctrl.sample_rate_sel, SAMPLE_24MHZ, "sample");
		chk(ctrl.dimming_input_hysteresis, 16'h3, "hyst");
		chk({ctrl.positive_out_on, ctrl.negative_out_on}, 16'h0, "pins off");
		chk({ctrl.positive_out_pulldown, ctrl.negative_out_pulldown}, 16'h3, "pd");
		@(posedge sys_clk);
		pos_pin <= 1'h1;
		neg_pin <= 1'h1;
		repeat (2) settle();
		chk({ctrl.positive_out_on, ctrl.negative_out_on}, 16'h3, "pins on");
		@(posedge sys_clk);
		pos_pin <= 1'h0;
		neg_pin <= 1'h0;
		$display("test masks done");
	endtask : t_masks

	task automatic t_modes;
		for (int k = 0; k < 5; k++) begin
			wr(ADDR_BIAS_A, {MODES[k], 5'h06});
			chk(ctrl.bias_mode_select, MODES[k], "mode");
			chk({ctrl.positive_out_on, ctrl.negative_out_on}, k ? 16'h3 : 16'h0, "on");
		end
		$display("test modes done");
	endtask : t_modes

	task automatic t_faults;
		wr(ADDR_BIAS_A, 8'h84);
		wr(ADDR_BIAS_C, 8'h20);
		for (int m = 0; m < 3; m++) begin
			wr(ADDR_BIAS_B, SHORT_MODES[m]);
			pulse(6'h08, 5);
			rd(ADDR_FLAGS);
			chk(rdata, 8'h00, "short filter");
			pulse(6'h08, 30);
			settle();
			chk({ctrl.backlight_on, ctrl.positive_out_on}, SHORT_KEEP[m], "short");
			rd(ADDR_FLAGS);
			chk(rdata, 8'h08, "short flag");
			settle();
			chk({ctrl.backlight_on, ctrl.positive_out_on}, 16'h3, "recover");
		end
		pulse(6'h33, 1);
		rd(ADDR_FLAGS);
		chk(rdata, 8'h63, "flags");
		rd(ADDR_FLAGS);
		chk(rdata, 8'h00, "cleared");
		$display("test faults done");
	endtask : t_faults

	task automatic t_soft_reset;
		wr(ADDR_ENABLE, 8'h80);
		t_reset_values();
		$display("test soft reset done");
	endtask : t_soft_reset

	// ****************************************************************
	// Sequence and watchdog
	// ****************************************************************
	initial begin
		sys_clk = 1'h0;
		rst_n = 1'h0;
		pos_pin = 1'h0;
		neg_pin = 1'h0;
		fault = '0;
		errors = 0;
		checks = 0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'h1;
		t_reset_values();
		t_dimming();
		t_masks();
		t_modes();
		t_faults();
		t_soft_reset();
		test_done();
	end

	initial begin
		repeat (30000) @(posedge sys_clk);
		errors++;
		$display("BAD %0t watchdog expired", $time);
		test_done();
	end

endmodule : testbench

`default_nettype wire
